// ### hw/iot_channel.sv
// One io timer channel with AXI4-Lite register access
//
// Contract
// - 16-bit counter decrements once per enabled count clock.
// - Each channel has 16-bit reload and 16-bit measure registers.
// - Exactly one software-selected mode: three input, four output modes.
// - Start by software enable write or external edge/level trigger.
// - Measure modes: count down, copy counter to measure on capture.
// - Measure-clear: counter set to FFFF on capture, keeps counting.
// - Measure-free-run: capture leaves counting; underflow wraps to FFFF.
// - Measure modes flag underflow and capture events.
// - Noise mode: starts at valid level; underflow flags and stops.
// - Noise mode: invalid level halts; valid again reloads and resumes.
// - Noise mode: stops at underflow or software enable clear.
// - PWM: enable loads reload 0 and starts counting.
// - PWM: underflows reload alternately from reload 1 and reload 0.
// - PWM: output toggles at start and underflow; disable stops at once.
// - PWM: event flag only on every even-numbered underflow.
// - Single-shot: load reload 0, toggle at start and underflow, stop.
// - Delayed: start from preload, reload at first, stop at second underflow.
// - Delayed: toggle at both underflows, flag events at both.
// - Continuous: start from preload, reload 0 every underflow, until disabled.
// - Continuous: toggle at start and every underflow, flag each underflow.
// - Mode field: 000 single, 001 delayed, 010 cont, 011 PWM, 10x measure, 11x noise.
// - 2-bit field selects one of four count clock bus lines.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module iot_channel (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  clk_bus,
    input  wire logic        ext_in,
    input  wire logic        capture_in,
    output logic             pulse_out,
    output logic             event_out,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // Pin synchronisers; stage one feeds only stage two
    logic [3:0] bus_s1, bus_s2, bus_d;
    logic       ext_s1, ext_s2, ext_d;
    logic       cap_s1, cap_s2, cap_d;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_s1 <= 4'h0; bus_s2 <= 4'h0; bus_d <= 4'h0;
            ext_s1 <= 1'b0; ext_s2 <= 1'b0; ext_d <= 1'b0;
            cap_s1 <= 1'b0; cap_s2 <= 1'b0; cap_d <= 1'b0;
        end else begin
            bus_s1 <= clk_bus; bus_s2 <= bus_s1; bus_d <= bus_s2;
            ext_s1 <= ext_in;  ext_s2 <= ext_s1; ext_d <= ext_s2;
            cap_s1 <= capture_in; cap_s2 <= cap_s1; cap_d <= cap_s2;
        end
    end

    // Registers
    logic [11:0] ctrl;
    logic [15:0] cnt, reload0, reload1, measure;
    logic        run, flag_under, flag_capt, pwm_phase, shot_second, noise_armed;

    iot_pkg::iot_mode_type mode;
    iot_pkg::iot_ext_type  ext_sel;
    logic [1:0] cks;
    logic       ext_en;
    assign mode    = iot_pkg::iot_mode_type'(ctrl[iot_pkg::CTRL_MODE_LSB +: 3]);
    assign ext_sel = iot_pkg::iot_ext_type'(ctrl[iot_pkg::CTRL_EXT_LSB +: 3]);
    assign ext_en  = ctrl[iot_pkg::CTRL_EEN_BIT];
    assign cks     = ctrl[iot_pkg::CTRL_CKS_LSB +: 2];

    // Mode classes
    wire is_measure = (mode == iot_pkg::MODE_MCLEAR) || (mode == iot_pkg::MODE_MFREE);
    wire is_noise   = mode[2] & mode[1];

    // Count tick: rising edge of selected bus line
    wire tick = bus_s2[cks] & ~bus_d[cks];

    // External trigger detection
    wire ext_rise = ext_s2 & ~ext_d;
    wire ext_fall = ~ext_s2 & ext_d;
    logic ext_trig;
    always_comb begin
        case (ext_sel)
            iot_pkg::EXT_RISE: ext_trig = ext_rise;
            iot_pkg::EXT_FALL: ext_trig = ext_fall;
            iot_pkg::EXT_BOTH: ext_trig = ext_rise | ext_fall;
            iot_pkg::EXT_HIGH: ext_trig = ext_s2;
            iot_pkg::EXT_LOW:  ext_trig = ~ext_s2;
            default:           ext_trig = 1'b0;
        endcase
    end
    // Noise mode valid level follows the level selection
    wire noise_valid = (ext_sel == iot_pkg::EXT_LOW) ? ~ext_s2 : ext_s2;
    wire capture     = cap_s2 & ~cap_d;

    // Bus write handshake: take address and data in either order
    wire         aw_held = ~s_axi_awready;
    wire         w_held  = ~s_axi_wready;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire         wr_fire = aw_held & w_held & ~s_axi_bvalid;
    wire         wr_ctrl = wr_fire && aw_addr == iot_pkg::OFF_CTRL;
    wire         wr_cnt  = wr_fire && aw_addr == iot_pkg::OFF_CNT;
    wire         wr_rl0  = wr_fire && aw_addr == iot_pkg::OFF_RELOAD0;
    wire         wr_rl1  = wr_fire && aw_addr == iot_pkg::OFF_RELOAD1;
    wire         wr_st   = wr_fire && aw_addr == iot_pkg::OFF_STATUS;
    wire         wr_en   = wr_fire && aw_addr == iot_pkg::OFF_COUNT_EN && w_strb[0];
    wire         wr_map  = wr_ctrl | wr_cnt | wr_rl0 | wr_rl1 | wr_st
                           | (wr_fire && aw_addr == iot_pkg::OFF_COUNT_EN);
    wire         sw_start = wr_en &  w_data[0];
    wire         sw_stop  = wr_en & ~w_data[0];

    // Merge byte lanes into a 16-bit value
    function automatic logic [15:0] iot_merge(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
        iot_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : iot_merge
    // Control is 12 bits wide; merge at 16 and keep the low part
    wire [15:0] ctrl_wr = iot_merge({4'h0, ctrl}, w_data, w_strb);

    // Start conditions; disable write wins over an external trigger
    wire ext_start = ext_en & ext_trig & ~is_measure & ~is_noise & ~run;
    wire start     = (sw_start | ext_start) & ~sw_stop;
    wire under     = run & tick & (cnt == 16'h0000);

    // Counter next value and control per mode
    logic [15:0] next_cnt;
    logic        next_run, next_phase, next_second, next_armed, toggle, ev_under;
    always_comb begin
        next_cnt    = cnt;
        next_run    = run;
        next_phase  = pwm_phase;
        next_second = shot_second;
        next_armed  = noise_armed;
        toggle      = 1'b0;
        ev_under    = 1'b0;
        if (start) begin
            next_run    = 1'b1;
            next_phase  = 1'b0;
            next_second = 1'b0;
            next_armed  = 1'b0;
            case (mode)
                iot_pkg::MODE_PWM: begin
                    next_cnt = reload0;
                    toggle   = 1'b1;
                end
                iot_pkg::MODE_SINGLE: begin
                    next_cnt = reload0;
                    toggle   = 1'b1;
                end
                iot_pkg::MODE_CONT: toggle = 1'b1;
                iot_pkg::MODE_NOISE, iot_pkg::MODE_NOISE2: next_cnt = reload0;
                default: next_cnt = cnt;
            endcase
        end else if (sw_stop) begin
            next_run   = 1'b0;
            next_armed = 1'b0;
        end else if (run) begin
            case (mode)
                iot_pkg::MODE_MCLEAR, iot_pkg::MODE_MFREE: begin
                    if (capture && mode == iot_pkg::MODE_MCLEAR)
                        next_cnt = iot_pkg::CNT_FULL;
                    else if (tick)
                        next_cnt = cnt - 16'h0001;
                    ev_under = under;
                end
                iot_pkg::MODE_NOISE, iot_pkg::MODE_NOISE2: begin
                    if (!noise_valid) begin
                        next_armed = 1'b1;
                    end else if (noise_armed) begin
                        next_armed = 1'b0;
                        next_cnt   = reload0;
                    end else if (under) begin
                        next_run = 1'b0;
                        ev_under = 1'b1;
                    end else if (tick) begin
                        next_cnt = cnt - 16'h0001;
                    end
                end
                iot_pkg::MODE_PWM: begin
                    if (under) begin
                        next_cnt   = pwm_phase ? reload0 : reload1;
                        next_phase = ~pwm_phase;
                        toggle     = 1'b1;
                        ev_under   = pwm_phase;
                    end else if (tick) begin
                        next_cnt = cnt - 16'h0001;
                    end
                end
                iot_pkg::MODE_SINGLE: begin
                    if (under) begin
                        next_run = 1'b0;
                        toggle   = 1'b1;
                        ev_under = 1'b1;
                    end else if (tick) begin
                        next_cnt = cnt - 16'h0001;
                    end
                end
                iot_pkg::MODE_DELAYED: begin
                    if (under) begin
                        next_cnt    = reload0;
                        next_second = 1'b1;
                        next_run    = ~shot_second;
                        toggle      = 1'b1;
                        ev_under    = 1'b1;
                    end else if (tick) begin
                        next_cnt = cnt - 16'h0001;
                    end
                end
                iot_pkg::MODE_CONT: begin
                    if (under) begin
                        next_cnt = reload0;
                        toggle   = 1'b1;
                        ev_under = 1'b1;
                    end else if (tick) begin
                        next_cnt = cnt - 16'h0001;
                    end
                end
                default: next_cnt = cnt;
            endcase
        end else if (is_noise && ext_en) begin
            // Restart needs the level to go invalid first, so a held level fires once
            if (!noise_valid) begin
                next_armed = 1'b1;
            end else if (noise_armed) begin
                next_armed = 1'b0;
                next_run   = 1'b1;
                next_cnt   = reload0;
            end
        end
        // Software counter write overrides when stopped
        if (wr_cnt && !run)
            next_cnt = iot_merge(cnt, w_data, w_strb);
    end

    wire ev_capt = run & is_measure & capture;

    // Channel state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt         <= iot_pkg::CNT_RESET;
            run         <= 1'b0;
            pwm_phase   <= 1'b0;
            shot_second <= 1'b0;
            noise_armed <= 1'b0;
            pulse_out   <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            run         <= next_run;
            pwm_phase   <= next_phase;
            shot_second <= next_second;
            noise_armed <= next_armed;
            pulse_out   <= pulse_out ^ toggle;
        end
    end

    // Configuration, measure and sticky flags; set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl       <= iot_pkg::CTRL_RESET;
            reload0    <= iot_pkg::CNT_RESET;
            reload1    <= iot_pkg::CNT_RESET;
            measure    <= iot_pkg::CNT_RESET;
            flag_under <= 1'b0;
            flag_capt  <= 1'b0;
            event_out  <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl <= ctrl_wr[11:0];
            if (wr_rl0)
                reload0 <= iot_merge(reload0, w_data, w_strb);
            if (wr_rl1)
                reload1 <= iot_merge(reload1, w_data, w_strb);
            if (ev_capt)
                measure <= cnt;
            flag_under <= ev_under | (flag_under & ~(wr_st & w_data[iot_pkg::ST_UNDER_BIT]));
            flag_capt  <= ev_capt | (flag_capt & ~(wr_st & w_data[iot_pkg::ST_CAPT_BIT]));
            event_out  <= ev_under | ev_capt;
        end
    end

    // Bus write channel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1; s_axi_wready <= 1'b1; aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000; w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= iot_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? iot_pkg::RESP_OKAY : iot_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read data select
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            iot_pkg::OFF_CTRL:     rd_mux = {20'h00000, ctrl};
            iot_pkg::OFF_CNT:      rd_mux = {16'h0000, cnt};
            iot_pkg::OFF_RELOAD0:  rd_mux = {16'h0000, reload0};
            iot_pkg::OFF_RELOAD1:  rd_mux = {16'h0000, reload1};
            iot_pkg::OFF_MEASURE:  rd_mux = {16'h0000, measure};
            iot_pkg::OFF_STATUS:   rd_mux = {28'h0000000, pulse_out, run, flag_capt, flag_under};
            iot_pkg::OFF_COUNT_EN: rd_mux = {31'h00000000, run};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Bus read channel, one cycle answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= iot_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? iot_pkg::RESP_OKAY : iot_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Assertions
    property p_reload_single;
        @(posedge clk) disable iff (!nrst)
        (start && mode == iot_pkg::MODE_SINGLE) |=> (cnt == $past(reload0) && run);
    endproperty
    a_reload_single: assert property (p_reload_single) else $error("single load bad");

    property p_pwm_start;
        @(posedge clk) disable iff (!nrst)
        (start && mode == iot_pkg::MODE_PWM) |=> (cnt == $past(reload0) && pulse_out != $past(pulse_out));
    endproperty
    a_pwm_start: assert property (p_pwm_start) else $error("pwm start bad");

    property p_pwm_alt;
        @(posedge clk) disable iff (!nrst)
        (under && mode == iot_pkg::MODE_PWM && !pwm_phase && !start && !sw_stop)
            |=> (cnt == $past(reload1) && flag_under == $past(flag_under));
    endproperty
    a_pwm_alt: assert property (p_pwm_alt) else $error("pwm alternate bad");

    property p_stop;
        @(posedge clk) disable iff (!nrst)
        (sw_stop && !sw_start) |=> !run;
    endproperty
    a_stop: assert property (p_stop) else $error("stop failed");

    property p_clear_capture;
        @(posedge clk) disable iff (!nrst)
        (run && mode == iot_pkg::MODE_MCLEAR && capture && !start && !sw_stop)
            |=> (cnt == iot_pkg::CNT_FULL && measure == $past(cnt) && flag_capt);
    endproperty
    a_clear_capture: assert property (p_clear_capture) else $error("clear capture bad");

    property p_free_wrap;
        @(posedge clk) disable iff (!nrst)
        (under && mode == iot_pkg::MODE_MFREE && !start && !sw_stop)
            |=> (cnt == iot_pkg::CNT_FULL && run && flag_under);
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("free wrap bad");

    property p_single_end;
        @(posedge clk) disable iff (!nrst)
        (under && mode == iot_pkg::MODE_SINGLE && !start && !sw_stop)
            |=> (!run && event_out && pulse_out != $past(pulse_out));
    endproperty
    a_single_end: assert property (p_single_end) else $error("single end bad");

    property p_cont;
        @(posedge clk) disable iff (!nrst)
        (under && mode == iot_pkg::MODE_CONT && !start && !sw_stop)
            |=> (cnt == $past(reload0) && run && event_out && pulse_out != $past(pulse_out));
    endproperty
    a_cont: assert property (p_cont) else $error("continuous bad");

    cover property (@(posedge clk) disable iff (!nrst) under && mode == iot_pkg::MODE_PWM);
    cover property (@(posedge clk) disable iff (!nrst) ev_capt);
    cover property (@(posedge clk) disable iff (!nrst) under && is_noise);
endmodule : iot_channel

// ### hw/iot_pkg.sv
// Package of constants for the io timer channel block
package iot_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CNT     = 8'h04;
    localparam logic [7:0] OFF_RELOAD0 = 8'h08;
    localparam logic [7:0] OFF_RELOAD1 = 8'h0c;
    localparam logic [7:0] OFF_MEASURE = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;
    localparam logic [7:0] OFF_COUNT_EN = 8'h18;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EXT_LSB  = 4;
    localparam int CTRL_EEN_BIT  = 7;
    localparam int CTRL_CKS_LSB  = 8;
    // Status bit positions
    localparam int ST_UNDER_BIT = 0;
    localparam int ST_CAPT_BIT  = 1;
    localparam int ST_RUN_BIT   = 2;
    localparam int ST_OUT_BIT   = 3;
    // Reset values and constants
    localparam logic [15:0] CNT_FULL   = 16'hffff;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    // Operating modes
    typedef enum logic [2:0] {
        MODE_SINGLE  = 3'b000,
        MODE_DELAYED = 3'b001,
        MODE_CONT    = 3'b010,
        MODE_PWM     = 3'b011,
        MODE_MCLEAR  = 3'b100,
        MODE_MFREE   = 3'b101,
        MODE_NOISE   = 3'b110,
        MODE_NOISE2  = 3'b111
    } iot_mode_type;
    // External enable detection
    typedef enum logic [2:0] {
        EXT_RISE = 3'b000,
        EXT_FALL = 3'b001,
        EXT_BOTH = 3'b010,
        EXT_HIGH = 3'b011,
        EXT_LOW  = 3'b100
    } iot_ext_type;
endpackage : iot_pkg

// ### tb/iot_channel_tb_top.sv
// Self-checking bench for one io timer channel
`timescale 1ns/1ps
module iot_channel_tb_top;
    logic        clk, nrst, ext_in, capture_in, clr, pulse_out, event_out;
    logic [3:0]  clk_bus, wstrb;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          toggles, events, gap, gap2, bad_count, n_tests, cyc, n;

    iot_channel i_dut (
        .clk(clk), .nrst(nrst), .clk_bus(clk_bus), .ext_in(ext_in),
        .capture_in(capture_in), .pulse_out(pulse_out), .event_out(event_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    iot_pin_model i_pins (
        .clk(clk), .clr(clr), .pulse_out(pulse_out), .event_out(event_out),
        .clk_bus(clk_bus), .toggles(toggles), .events(events), .gap(gap), .gap2(gap2));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, well above the whole sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(d & m, e);
    endtask : rdm
    // Stopped channel is set up, flags cleared, monitor zeroed, then enabled
    task automatic start(input logic [31:0] c, cn, r0, r1);
        wr(iot_pkg::OFF_CTRL, c);
        wr(iot_pkg::OFF_CNT, cn);
        wr(iot_pkg::OFF_RELOAD0, r0);
        wr(iot_pkg::OFF_RELOAD1, r1);
        wr(iot_pkg::OFF_STATUS, 32'h3);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr(iot_pkg::OFF_COUNT_EN, 32'h1);
    endtask : start
    task automatic halt(input int w);
        wr(iot_pkg::OFF_COUNT_EN, 32'h0);
        repeat (w) @(posedge clk);
    endtask : halt
    task automatic cap;
        capture_in <= 1'b1;
        repeat (4) @(posedge clk);
        capture_in <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : cap
    task automatic wait_stop;
        do rd(iot_pkg::OFF_STATUS); while (d[iot_pkg::ST_RUN_BIT] !== 1'b0);
        repeat (4) @(posedge clk);
    endtask : wait_stop

    initial begin
        {nrst, ext_in, capture_in, clr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset values, unmapped address, read-only and 16-bit registers
        rdm(iot_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
        rdm(iot_pkg::OFF_STATUS, 32'hffffffff, 32'h0);
        rd(8'h40);
        chk(r, iot_pkg::RESP_SLVERR);
        wr(iot_pkg::OFF_MEASURE, 32'h1234);
        chk(r, iot_pkg::RESP_SLVERR);
        rdm(iot_pkg::OFF_MEASURE, 32'hffffffff, 32'h0);
        wr(iot_pkg::OFF_RELOAD1, 32'h1abcd);
        chk(r, iot_pkg::RESP_OKAY);
        rdm(iot_pkg::OFF_RELOAD1, 32'hffffffff, 32'habcd);
        // Continuous mode on each count clock line; tick is 2*(k+2) cycles
        for (int k = 0; k < 4; k++) begin
            start(32'h2 | (k << 8), 32'h0, 32'h3, 32'h0);
            repeat (40 * (k + 2)) @(posedge clk);
            chk(gap, 8 * (k + 2));
            halt(8);
            n = toggles;
            chk(events, n - 1);
            repeat (20 * (k + 2)) @(posedge clk);
            chk(toggles, n);
        end
        // PWM: high and low phases alternate, flag on even underflows
        start(32'h3, 32'h0, 32'h2, 32'h5);
        repeat (200) @(posedge clk);
        chk(gap + gap2, 36);
        halt(8);
        n = toggles;
        chk(events, (n - 1) / 2);
        repeat (40) @(posedge clk);
        chk(toggles, n);
        // Single-shot, then delayed single-shot
        start(32'h0, 32'h0, 32'h5, 32'h0);
        wait_stop();
        chk(toggles, 2);
        chk(events, 1);
        start(32'h1, 32'h4, 32'h2, 32'h0);
        wait_stop();
        chk(toggles, 2);
        chk(events, 2);
        chk(gap, 12);
        // Measure-clear: capture copies count, counter restarts from full
        start(32'h4, 32'h100, 32'h0, 32'h0);
        repeat (100) @(posedge clk);
        cap();
        rd(iot_pkg::OFF_CNT);
        chk(d >= 32'hff00, 1'b1);
        rd(iot_pkg::OFF_MEASURE);
        chk(d < 32'h100 && d > 32'h0, 1'b1);
        rdm(iot_pkg::OFF_STATUS, 32'h2, 32'h2);
        chk(events, 1);
        halt(2);
        // Measure-free-run: wraps at underflow, capture leaves the count alone
        start(32'h5, 32'h2, 32'h0, 32'h0);
        repeat (60) @(posedge clk);
        rdm(iot_pkg::OFF_STATUS, 32'h5, 32'h5);
        cap();
        rd(iot_pkg::OFF_MEASURE);
        n = d;
        rd(iot_pkg::OFF_CNT);
        chk(d <= n && n > 32'hff00, 1'b1);
        halt(2);
        // Noise: short valid level gives nothing, long one fires once and stops
        start(32'hb6, 32'h0, 32'h4, 32'h0);
        ext_in <= 1'b1;
        repeat (12) @(posedge clk);
        ext_in <= 1'b0;
        repeat (30) @(posedge clk);
        chk(events, 0);
        ext_in <= 1'b1;
        repeat (40) @(posedge clk);
        ext_in <= 1'b0;
        chk(events, 1);
        rdm(iot_pkg::OFF_STATUS, 32'h5, 32'h1);
        halt(2);
        // External start for every detection kind
        for (int e = 0; e < 5; e++) begin
            ext_in <= (e == 1 || e == 4);
            wr(iot_pkg::OFF_CTRL, 32'h82 | (e << 4));
            repeat (8) @(posedge clk);
            rdm(iot_pkg::OFF_STATUS, 32'h4, 32'h0);
            ext_in <= !(e == 1 || e == 4);
            repeat (8) @(posedge clk);
            rdm(iot_pkg::OFF_STATUS, 32'h4, 32'h4);
            wr(iot_pkg::OFF_CTRL, 32'h2);
            halt(2);
        end
        end_sim();
    end
endmodule : iot_channel_tb_top

// ### tb/iot_pin_model.sv
// Far-side pin model: shared count clock bus and output monitor
`timescale 1ns/1ps
module iot_pin_model (
    input  wire logic  clk,
    input  wire logic  clr,
    input  wire logic  pulse_out,
    input  wire logic  event_out,
    output logic [3:0] clk_bus = 4'h0,
    output int         toggles,
    output int         events,
    output int         gap,
    output int         gap2
);
    int   since;
    int   div [4] = '{default: 0};
    logic last = 1'b0;
    // Line k flips every k+2 cycles; the shared bus runs free
    always @(posedge clk) begin
        for (int k = 0; k < 4; k++) begin
            div[k] <= (div[k] == k + 1) ? 0 : div[k] + 1;
            if (div[k] == k + 1) clk_bus[k] <= ~clk_bus[k];
        end
    end
    // Toggles, events and last two gaps in clk cycles
    always @(posedge clk) begin
        last <= pulse_out;
        since <= since + 1;
        if (clr) begin
            toggles <= 0;
            events <= 0;
        end else begin
            if (event_out === 1'b1) events <= events + 1;
            if (pulse_out !== last) begin
                toggles <= toggles + 1;
                gap2 <= gap;
                gap <= since;
                since <= 1;
            end
        end
    end
endmodule : iot_pin_model
